// *** dv/sd_card_model.sv ***
`timescale 1ns/100ps
module sd_card_model
(
  input wire logic card_clk_i,
  input wire logic cmd_drv_i,
  input wire logic cmd_oe_i,
  input wire logic [7:0] data_drv_i,
  input wire logic [7:0] data_oe_i,
  input wire logic busy_i,
  output logic cmd_line_o,
  output logic [7:0] data_line_o,
  output logic [47:0] token_o = 48'h0,
  output logic [7:0] bits_o = 8'h00,
  output logic [47:0] dword_o = 48'h0
);
  logic [5:0] pos = 6'h00;
  logic dlive = 1'b0;

  // released lines float up on the card pull-ups
  assign cmd_line_o = cmd_oe_i ? cmd_drv_i : 1'b1;
  // a slow card holds the lowest line low while busy
  assign data_line_o = ((data_oe_i & data_drv_i) | ~data_oe_i) & {7'h7F, ~busy_i};

  // one command bit per rise, msb first; a frame spans 48 rises from its
  // start bit, so released highs of an open-drain token still belong to it
  always @(posedge card_clk_i)
  begin
    if (pos != 6'h00 || !cmd_line_o)
    begin
      token_o <= {token_o[46:0], cmd_line_o};
      pos <= (pos == 6'h2F) ? 6'h00 : pos + 6'h01;
    end
    // driven periods only, so a bit driven past the end bit is counted too
    if (cmd_oe_i)
      bits_o <= (pos == 6'h00 && !cmd_line_o) ? 8'h01 : bits_o + 8'h01;
    // data gathered at the width the enables show, fresh at each frame
    dlive <= |data_oe_i;
    if (data_oe_i == 8'h01)
      dword_o <= {(dlive ? dword_o[46:0] : 47'h0), data_line_o[0]};
    else if (data_oe_i == 8'h0F)
      dword_o <= {(dlive ? dword_o[43:0] : 44'h0), data_line_o[3:0]};
    else if (data_oe_i == 8'hFF)
      dword_o <= {(dlive ? dword_o[39:0] : 40'h0), data_line_o};
  end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/100ps
module tb;
  import sd_host_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic busy = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, card_clk, cmd_o, cmd_oe, cmd_in, irq, dma;
  logic [1:0] bresp, rresp, resp, act;
  logic [31:0] rdata, rd_v;
  logic [7:0] data_o, data_oe, data_in, bits;
  logic [47:0] token, dword;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;

  sd_card_host_adapter uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .card_clock_out_o(card_clk),
    .cmd_i(cmd_in), .cmd_o(cmd_o), .cmd_oe_o(cmd_oe), .data_i(data_in),
    .data_o(data_o), .data_oe_o(data_oe), .irq_o(irq), .dma_req_o(dma));

  sd_card_model card (.card_clk_i(card_clk), .cmd_drv_i(cmd_o), .cmd_oe_i(cmd_oe),
    .data_drv_i(data_o), .data_oe_i(data_oe), .busy_i(busy), .cmd_line_o(cmd_in),
    .data_line_o(data_in), .token_o(token), .bits_o(bits), .dword_o(dword));

  initial
    forever #2 mclk_i = ~mclk_i;

  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // each channel released at its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin
        do @(posedge mclk_i); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge mclk_i); while (!wready);
        wvalid <= 1'b0;
      end
    join
    while (!bvalid)
      @(posedge mclk_i);
    resp = bresp;
    bready <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge mclk_i); while (!rvalid);
    rd_v = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge mclk_i);
  endtask

  // act[1] clock or command activity, act[0] data drive
  task automatic quiet(input int n);
    act = 2'h0;
    repeat (n)
    begin
      @(posedge mclk_i);
      act = act | {card_clk | cmd_oe, |data_oe};
    end
  endtask

  function automatic logic [47:0] tok(input logic [5:0] idx, input logic [31:0] arg);
    logic [39:0] m;
    logic [6:0] c;
    m = {2'b01, idx, arg};
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
    return {m, c, 1'b1};
  endfunction

  task automatic t_reset();
    quiet(20);
    chk(act, 2'h0);
    rd(OFS_STATUS);
    chk(rd_v, 32'h0);
    rd(8'h40);
    chk({resp, rd_v}, {RESP_SLVERR, 32'h0});
    wr(8'h40, 32'h0);
    chk(resp, RESP_SLVERR);
    // power-up phase keeps clock and outputs off even when enabled
    wr(OFS_POWER, 32'h2);
    wr(OFS_CLKCR, 32'h100);
    quiet(100);
    chk(act, 2'h0);
  endtask

  task automatic t_cmd();
    wr(OFS_POWER, 32'h3);
    rd(OFS_STATUS);
    chk(rd_v[ST_CLK_RUN], 1'b1);
    wr(OFS_ARG, 32'hA5C3_0F96);
    wr(OFS_CMD, 32'h6A);
    do rd(OFS_STATUS); while (!rd_v[ST_CMD_SENT]);
    chk(token, tok(6'h2A, 32'hA5C3_0F96));
    chk(bits, 8'h30);
    chk({cmd_oe, irq}, 2'h1);
    wr(OFS_CLEAR, 32'h0);
    rd(OFS_STATUS);
    chk(rd_v[ST_CMD_SENT], 1'b1);
    wr(OFS_CLEAR, 32'h1);
    rd(OFS_STATUS);
    chk({rd_v[ST_CMD_SENT], irq}, 2'h0);
    // old card init: open drain, only the zero bits are driven
    wr(OFS_CFG, 32'h5);
    wr(OFS_CMD, 32'h41);
    do rd(OFS_STATUS); while (!rd_v[ST_CMD_SENT]);
    chk(token, tok(6'h01, 32'hA5C3_0F96));
    chk(bits, 48 - $countones(tok(6'h01, 32'hA5C3_0F96)));
    wr(OFS_CFG, 32'h0);
  endtask

  task automatic t_data();
    logic [7:0] cfg [3] = '{8'h08, 8'h0A, 8'h09};
    logic [7:0] msk [3] = '{8'h0F, 8'hFF, 8'h01};
    int sh [3] = '{4, 8, 1};
    busy <= 1'b1;
    wr(OFS_CLKCR, 32'h900);
    wr(OFS_TXDATA, 32'h8000_0001);
    quiet(200);
    chk(act[0], 1'b0);
    chk(dma, 1'b0);
    busy <= 1'b0;
    do @(posedge mclk_i); while (data_oe == 8'h00);
    chk(data_oe, 8'h01);
    do @(posedge mclk_i); while (data_oe != 8'h00);
    chk(dword, {15'h0000, 32'h8000_0001, 1'b1});
    chk(dma, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      wr(OFS_CFG, {24'h0, cfg[i]});
      wr(OFS_CLKCR, 32'h1100);
      wr(OFS_TXDATA, 32'h1234_5678);
      do @(posedge mclk_i); while (data_oe == 8'h00);
      chk(data_oe, msk[i]);
      do @(posedge mclk_i); while (data_oe != 8'h00);
      chk(dword, ({16'h0000, 32'h1234_5678} << sh[i]) | msk[i]);
    end
  endtask

  // power saving must stop the clock once both paths sit idle
  task automatic t_save();
    wr(OFS_CLKCR, 32'h300);
    repeat (100) @(posedge mclk_i);
    quiet(50);
    chk(act, 2'h0);
    rd(OFS_STATUS);
    chk(rd_v[ST_CLK_RUN], 1'b0);
  endtask

  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_cmd();
    t_data();
    t_save();
    stop_test();
  end
endmodule

// *** hw/sd_card_host_adapter.sv ***
`timescale 1ns/100ps
// Overview of operation
// - MMC data widths one, four, eight lines
// - SD cards use one or four lines
// - old MMC cards use lowest line only
// - single line until initialization marked done
// - no SPI mode, native protocol only
// - separate command and data output enables
// - open-drain command only for old MMC init
// - data lines always driven push-pull
// - one bit per line per card clock
// - card clock programmable up to card maximum
// - registers bus side, card logic adapter side; here both run on mclk_i with no crossing
// - no data sent while card holds busy
// - writing one clears matching sticky flag
// - outputs disabled in power-off and power-up
// - card clock divided or bypassed
// - clock stopped at reset, off, idle-saving
// - stream mode only for MMC targets
// - one card or one MMC stack addressed
// - interrupt and DMA request outputs
// - 48-bit command token format
// - command line released unless sending
// - seven-bit CRC over leading bits
module sd_card_host_adapter
  import sd_host_pkg::*;
(
  input logic mclk_i,
  input logic rst_n_i,
  input logic [sd_host_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input logic [sd_host_pkg::DATA_W-1:0] s_axi_wdata_i,
  input logic [3:0] s_axi_wstrb_i,
  input logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input logic s_axi_bready_i,
  input logic [sd_host_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [sd_host_pkg::DATA_W-1:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input logic s_axi_rready_i,
  output logic card_clock_out_o,
  input logic cmd_i,
  output logic cmd_o,
  output logic cmd_oe_o,
  input logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic [7:0] data_oe_o,
  output logic irq_o,
  output logic dma_req_o
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [DATA_W-1:0] rdata;
    power_t power;
    logic [CLKCR_W-1:0] clkcr;
    logic [CFG_W-1:0] cfg;
    logic [DATA_W-1:0] arg;
    logic [CMD_IDX_W-1:0] cmd_idx;
    logic cmd_pending;
    logic [DATA_W-1:0] txdata;
    logic tx_pending;
    logic [STICKY_W-1:0] sticky;
    logic cmd_busy;
    logic [5:0] cmd_cnt;
    logic [39:0] cmd_sh;
    logic [CRC_W-1:0] crc;
    logic cmd_bit;
    logic cmd_out;
    logic cmd_oe;
    logic dat_busy;
    logic [5:0] dat_cnt;
    logic [DATA_W-1:0] dat_sh;
    bus_width_t dat_width;
    logic [7:0] dat_out;
    logic [7:0] dat_oe;
    logic irq;
    logic dma;
  } host_state_t;

  host_state_t s_q;
  host_state_t s_d;
  logic card_fall;
  logic card_running;
  logic path_idle;
  logic crc_bit;
  logic [CRC_W-1:0] crc_in;
  logic [CRC_W-1:0] crc_next;
  logic set_sent;
  logic set_done;
  logic [STICKY_W-1:0] clr;

  // byte lanes of a write merged over the old word
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_w,
                                                    input logic [DATA_W-1:0] new_w,
                                                    input logic [3:0] strb);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_w[i*8 +: 8];
    end
    return res;
  endfunction

  // width actually used for a transfer, narrowed by card kind and init state
  function automatic bus_width_t eff_width(input logic [CFG_W-1:0] cfg,
                                           input logic [1:0] req);
    bus_width_t w;
    w = BUS_1;
    if (cfg[CFG_INIT_DONE_BIT] && card_t'(cfg[CFG_TYPE_LSB +: 2]) != CARD_MMC_LEGACY)
    begin
      unique case (req)
        2'b01: w = BUS_4;
        2'b10: w = (card_t'(cfg[CFG_TYPE_LSB +: 2]) == CARD_SD) ? BUS_4 : BUS_8;
        default: w = BUS_1;
      endcase
    end
    return w;
  endfunction

  // card clock source; the core runs entirely on mclk_i, the AXI4-Lite slave
  // included, so no crossing is needed
  sd_clock_gen #(
    .DIV_W(CLK_DIV_W)
  ) u_clock_gen (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .run_i(s_q.power == PWR_ON && s_q.clkcr[CLK_EN_BIT]),
    .bypass_i(s_q.clkcr[CLK_BYPASS_BIT]),
    .div_i(s_q.clkcr[CLK_DIV_LSB +: CLK_DIV_W]),
    .pwrsav_i(s_q.clkcr[CLK_PWRSAV_BIT]),
    .idle_i(path_idle),
    .card_clk_o(card_clock_out_o),
    .fall_o(card_fall),
    .running_o(card_running)
  );

  // checksum step shared by the token load and the payload shifting
  sd_crc7_step u_crc7 (
    .crc_i(crc_in),
    .bit_i(crc_bit),
    .crc_o(crc_next)
  );

  // pending work keeps the clock alive so power saving never stalls a start
  assign path_idle = !(s_q.cmd_busy || s_q.cmd_pending || s_q.dat_busy || s_q.tx_pending);
  assign crc_in = s_q.cmd_busy ? s_q.crc : '0;
  assign crc_bit = s_q.cmd_busy ? s_q.cmd_sh[39] : 1'h0;

  // card side sequencing, then register access, then outputs
  always_comb
  begin
    s_d = s_q;
    set_sent = 1'h0;
    set_done = 1'h0;
    clr = '0;
    // bits change on the falling card edge, sampled by the card on the rise
    if (card_fall)
    begin
      if (!s_q.cmd_busy)
      begin
        if (s_q.cmd_pending)
        begin
          s_d.cmd_busy = 1'h1;
          s_d.cmd_pending = 1'h0;
          s_d.cmd_cnt = '0;
          s_d.cmd_bit = 1'h0;
          s_d.cmd_sh = {1'h1, s_q.cmd_idx, s_q.arg, 1'h0};
          s_d.crc = crc_next;
        end
      end
      else if (s_q.cmd_cnt == TOKEN_LAST)
      begin
        s_d.cmd_busy = 1'h0;
        set_sent = 1'h1;
      end
      else
      begin
        s_d.cmd_cnt = s_q.cmd_cnt + 6'h01;
        if (s_d.cmd_cnt < PAYLOAD_BITS)
        begin
          s_d.cmd_bit = s_q.cmd_sh[39];
          s_d.crc = crc_next;
          s_d.cmd_sh = {s_q.cmd_sh[38:0], 1'h0};
        end
        else if (s_d.cmd_cnt < TOKEN_LAST)
        begin
          s_d.cmd_bit = s_q.crc[CRC_W-1];
          s_d.crc = {s_q.crc[CRC_W-2:0], 1'h0};
        end
        else
          s_d.cmd_bit = 1'h1;
      end
      // data word: start bit, data beats, end bit on every active line
      if (!s_q.dat_busy)
      begin
        if (s_q.tx_pending && data_i[0])
        begin
          s_d.dat_busy = 1'h1;
          s_d.tx_pending = 1'h0;
          s_d.dat_cnt = '0;
          s_d.dat_sh = s_q.txdata;
          s_d.dat_width = eff_width(s_q.cfg, s_q.clkcr[CLK_WID_LSB +: 2]);
          s_d.dat_out = 8'h00;
        end
      end
      else
      begin
        logic [5:0] beats;
        beats = BEATS_1;
        unique case (s_q.dat_width)
          BUS_4: beats = BEATS_4;
          BUS_8: beats = BEATS_8;
          default: beats = BEATS_1;
        endcase
        s_d.dat_cnt = s_q.dat_cnt + 6'h01;
        if (s_q.dat_cnt == beats + 6'h01)
        begin
          s_d.dat_busy = 1'h0;
          set_done = 1'h1;
        end
        else if (s_d.dat_cnt <= beats)
        begin
          unique case (s_q.dat_width)
            BUS_4:
            begin
              s_d.dat_out = {4'h0, s_q.dat_sh[31:28]};
              s_d.dat_sh = {s_q.dat_sh[27:0], 4'h0};
            end
            BUS_8:
            begin
              s_d.dat_out = s_q.dat_sh[31:24];
              s_d.dat_sh = {s_q.dat_sh[23:0], 8'h00};
            end
            default:
            begin
              s_d.dat_out = {7'h00, s_q.dat_sh[31]};
              s_d.dat_sh = {s_q.dat_sh[30:0], 1'h0};
            end
          endcase
        end
        else
          s_d.dat_out = 8'hFF;
      end
    end

    // AXI4-Lite address and data accepted independently, in either order
    if (s_axi_awvalid_i && s_q.awready)
    begin
      s_d.aw_have = 1'h1;
      s_d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_q.wready)
    begin
      s_d.w_have = 1'h1;
      s_d.wdata = s_axi_wdata_i;
      s_d.wstrb = s_axi_wstrb_i;
    end
    if (s_q.bvalid && s_axi_bready_i)
      s_d.bvalid = 1'h0;
    // register writes land on the core clock directly
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
    begin
      logic [DATA_W-1:0] wv;
      wv = 32'h0000_0000;
      s_d.aw_have = 1'h0;
      s_d.w_have = 1'h0;
      s_d.bvalid = 1'h1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.awaddr)
        OFS_POWER:
        begin
          wv = merge_bytes({30'h0, s_q.power}, s_q.wdata, s_q.wstrb);
          s_d.power = power_t'(wv[1:0]);
        end
        OFS_CLKCR:
        begin
          wv = merge_bytes({19'h0, s_q.clkcr}, s_q.wdata, s_q.wstrb);
          s_d.clkcr = wv[CLKCR_W-1:0];
        end
        OFS_CFG:
        begin
          wv = merge_bytes({27'h0, s_q.cfg}, s_q.wdata, s_q.wstrb);
          s_d.cfg = wv[CFG_W-1:0];
          // stream transfers are meaningful only toward MMC targets
          s_d.cfg[CFG_STREAM_BIT] = wv[CFG_STREAM_BIT] &&
            (card_t'(wv[CFG_TYPE_LSB +: 2]) inside {CARD_MMC_LEGACY, CARD_MMC4});
        end
        OFS_ARG: s_d.arg = merge_bytes(s_q.arg, s_q.wdata, s_q.wstrb);
        OFS_CMD:
        begin
          wv = merge_bytes({25'h0, s_q.cmd_pending, s_q.cmd_idx}, s_q.wdata, s_q.wstrb);
          s_d.cmd_idx = wv[CMD_IDX_W-1:0];
          if (wv[CMD_EN_BIT])
            s_d.cmd_pending = 1'h1;
        end
        OFS_CLEAR:
        begin
          wv = merge_bytes(32'h0000_0000, s_q.wdata, s_q.wstrb);
          clr = wv[STICKY_W-1:0];
        end
        OFS_TXDATA:
        begin
          s_d.txdata = merge_bytes(s_q.txdata, s_q.wdata, s_q.wstrb);
          s_d.tx_pending = 1'h1;
        end
        OFS_STATUS: s_d.bresp = RESP_OKAY;
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;

    // reads answer one cycle after the address is taken
    if (s_q.rvalid && s_axi_rready_i)
      s_d.rvalid = 1'h0;
    if (s_axi_arvalid_i && s_q.arready)
    begin
      s_d.rvalid = 1'h1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        OFS_POWER: s_d.rdata[1:0] = s_q.power;
        OFS_CLKCR: s_d.rdata[CLKCR_W-1:0] = s_q.clkcr;
        OFS_CFG: s_d.rdata[CFG_W-1:0] = s_q.cfg;
        OFS_ARG: s_d.rdata = s_q.arg;
        OFS_CMD: s_d.rdata[CMD_EN_BIT:0] = {s_q.cmd_pending, s_q.cmd_idx};
        OFS_STATUS:
        begin
          s_d.rdata[STICKY_W-1:0] = s_q.sticky;
          s_d.rdata[ST_CMD_ACT] = s_q.cmd_busy;
          s_d.rdata[ST_DATA_ACT] = s_q.dat_busy;
          s_d.rdata[ST_BUSY] = !data_i[0];
          s_d.rdata[ST_CLK_RUN] = card_running;
        end
        OFS_CLEAR: s_d.rdata = 32'h0000_0000;
        OFS_TXDATA: s_d.rdata = s_q.txdata;
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end
    s_d.arready = !s_d.rvalid;

    // a flag event in the same cycle as its clear survives
    s_d.sticky = (s_q.sticky & ~clr) |
                 {set_done, set_sent};

    // pins; power states other than on release everything
    s_d.cmd_oe = 1'h0;
    s_d.cmd_out = 1'h0;
    s_d.dat_oe = 8'h00;
    if (s_d.power == PWR_ON)
    begin
      // only old MMC init uses open drain: drive low, release for high
      if (s_d.cfg[CFG_OD_BIT] && card_t'(s_d.cfg[CFG_TYPE_LSB +: 2]) == CARD_MMC_LEGACY)
        s_d.cmd_oe = s_d.cmd_busy && !s_d.cmd_bit;
      else
      begin
        s_d.cmd_oe = s_d.cmd_busy;
        s_d.cmd_out = s_d.cmd_bit;
      end
      if (s_d.dat_busy)
      begin
        unique case (s_d.dat_width)
          BUS_4: s_d.dat_oe = MASK_4;
          BUS_8: s_d.dat_oe = MASK_8;
          default: s_d.dat_oe = MASK_1;
        endcase
      end
    end
    // no mask here: any sticky event requests attention
    s_d.irq = |s_d.sticky;
    s_d.dma = (s_d.power == PWR_ON) && !s_d.tx_pending;
  end

  // single card and single command line; no chip select exists
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o = s_q.wready;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign cmd_o = s_q.cmd_out;
  assign cmd_oe_o = s_q.cmd_oe;
  assign data_o = s_q.dat_out;
  assign data_oe_o = s_q.dat_oe;
  assign irq_o = s_q.irq;
  assign dma_req_o = s_q.dma;

  a_cmd_hiz_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !s_q.cmd_busy |-> !cmd_oe_o) else $error("command line driven while idle");
  a_outputs_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_q.power != PWR_ON |-> (!cmd_oe_o && data_oe_o == 8'h00))
    else $error("card outputs enabled outside power on");
  a_open_drain_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cmd_oe_o && s_q.cfg[CFG_OD_BIT] && s_q.cfg[1:0] == CARD_MMC_LEGACY) |-> !cmd_o)
    else $error("open drain command drove high");
  a_sd_four_lines: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ($rose(s_q.dat_busy) && $past(s_q.cfg[1:0]) == CARD_SD && s_q.power == PWR_ON)
    |-> data_oe_o[7:4] == 4'h0) else $error("SD transfer used upper lines");
  a_legacy_one_line: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ($rose(s_q.dat_busy) && $past(s_q.cfg[1:0]) == CARD_MMC_LEGACY)
    |-> data_oe_o[7:1] == 7'h00) else $error("old MMC transfer used wide bus");
  a_default_narrow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ($rose(s_q.dat_busy) && !$past(s_q.cfg[CFG_INIT_DONE_BIT]))
    |-> s_q.dat_width == BUS_1) else $error("wide bus before init done");
  a_busy_withhold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(s_q.dat_busy) |-> $past(data_i[0])) else $error("data sent while card busy");
  a_clear_effect: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (clr[ST_CMD_SENT] && !set_sent) |=> !s_q.sticky[ST_CMD_SENT])
    else $error("clear write did not clear flag");
  a_set_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    set_sent |=> s_q.sticky[ST_CMD_SENT]) else $error("sent event lost");
  a_token_frame: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(s_q.cmd_busy) |-> ($past(s_q.cmd_bit) && $past(s_q.cmd_cnt) == TOKEN_LAST))
    else $error("token end bit or length wrong");
  a_start_bit: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(s_q.cmd_busy) |-> (!s_q.cmd_bit && !cmd_o)) else $error("start bit not zero");
endmodule

// *** hw/sd_clock_gen.sv ***
`timescale 1ns/100ps
module sd_clock_gen
  import sd_host_pkg::*;
#(
  parameter int DIV_W = sd_host_pkg::CLK_DIV_W
)
(
  input logic mclk_i,
  input logic rst_n_i,
  input logic run_i,
  input logic bypass_i,
  input logic [DIV_W-1:0] div_i,
  input logic pwrsav_i,
  input logic idle_i,
  output logic card_clk_o,
  output logic fall_o,
  output logic running_o
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic clk;
    logic fall;
    logic [3:0] idle_cnt;
  } clk_state_t;

  clk_state_t s_q;
  clk_state_t s_d;
  logic gated;

  // divider toggles the card clock; bypass toggles every adapter edge
  always_comb
  begin
    s_d = s_q;
    gated = !run_i || (pwrsav_i && s_q.idle_cnt == IDLE_PERIODS);
    if (gated)
    begin
      s_d.clk = 1'h0;
      s_d.cnt = '0;
    end
    else if (bypass_i || s_q.cnt >= div_i)
    begin
      s_d.clk = !s_q.clk;
      s_d.cnt = '0;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 1'h1;
    end
    s_d.fall = s_q.clk && !s_d.clk && !gated;
    // idle periods counted on falling edges so the count is in card clocks
    if (!idle_i)
      s_d.idle_cnt = 4'h0;
    else if (s_q.fall && s_q.idle_cnt != IDLE_PERIODS)
      s_d.idle_cnt = s_q.idle_cnt + 4'h1;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign card_clk_o = s_q.clk;
  // strobe leads the edge so bits move with the fall, half a period before the rise;
  // a registered strobe would move them onto the rise when the divider is zero
  assign fall_o = s_d.fall;
  assign running_o = !gated;

  a_clock_stopped: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !run_i |=> !card_clk_o) else $error("card clock runs while stopped");
  a_idle_gating: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pwrsav_i && idle_i && s_q.idle_cnt == IDLE_PERIODS) |=> !card_clk_o[*2])
    else $error("card clock not gated after idle periods");
endmodule

// *** hw/sd_crc7_step.sv ***
`timescale 1ns/100ps
module sd_crc7_step
  import sd_host_pkg::*;
(
  input logic [sd_host_pkg::CRC_W-1:0] crc_i,
  input logic bit_i,
  output logic [sd_host_pkg::CRC_W-1:0] crc_o
);
  logic fb;

  // one serial step of the x^7 + x^3 + 1 checksum
  always_comb
  begin
    fb = bit_i ^ crc_i[CRC_W-1];
    crc_o = {crc_i[CRC_W-2:0], 1'h0} ^ ({CRC_W{fb}} & CRC_POLY);
  end
endmodule

// *** hw/sd_host_pkg.sv ***
package sd_host_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_POWER = 8'h00;
  localparam logic [7:0] OFS_CLKCR = 8'h04;
  localparam logic [7:0] OFS_CFG = 8'h08;
  localparam logic [7:0] OFS_ARG = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CLEAR = 8'h18;
  localparam logic [7:0] OFS_TXDATA = 8'h1C;

  // clock control field layout
  localparam int CLKCR_W = 13;
  localparam int CLK_DIV_LSB = 0;
  localparam int CLK_DIV_W = 8;
  localparam int CLK_EN_BIT = 8;
  localparam int CLK_PWRSAV_BIT = 9;
  localparam int CLK_BYPASS_BIT = 10;
  localparam int CLK_WID_LSB = 11;

  // card configuration field layout
  localparam int CFG_W = 5;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_OD_BIT = 2;
  localparam int CFG_INIT_DONE_BIT = 3;
  localparam int CFG_STREAM_BIT = 4;

  // command register layout
  localparam int CMD_IDX_W = 6;
  localparam int CMD_EN_BIT = 6;

  // status bit positions
  localparam int ST_CMD_SENT = 0;
  localparam int ST_DATA_DONE = 1;
  localparam int ST_CMD_ACT = 2;
  localparam int ST_DATA_ACT = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_CLK_RUN = 5;
  localparam int STICKY_W = 2;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b00,
    PWR_RSVD = 2'b01,
    PWR_UP = 2'b10,
    PWR_ON = 2'b11
  } power_t;

  typedef enum logic [1:0] {
    CARD_SD = 2'b00,
    CARD_MMC_LEGACY = 2'b01,
    CARD_MMC4 = 2'b10,
    CARD_CEATA = 2'b11
  } card_t;

  typedef enum logic [1:0] {
    BUS_1 = 2'b00,
    BUS_4 = 2'b01,
    BUS_8 = 2'b10
  } bus_width_t;

  // command token and checksum
  localparam logic [5:0] TOKEN_LAST = 6'h2F;
  localparam logic [5:0] PAYLOAD_BITS = 6'h28;
  localparam int CRC_W = 7;
  localparam logic [6:0] CRC_POLY = 7'h09;

  // data word sending, beats per width and active line masks
  localparam int DATA_W = 32;
  localparam logic [5:0] BEATS_1 = 6'h20;
  localparam logic [5:0] BEATS_4 = 6'h08;
  localparam logic [5:0] BEATS_8 = 6'h04;
  localparam logic [7:0] MASK_1 = 8'h01;
  localparam logic [7:0] MASK_4 = 8'h0F;
  localparam logic [7:0] MASK_8 = 8'hFF;

  // card clock idle periods before power saving stops it
  localparam logic [3:0] IDLE_PERIODS = 4'h8;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage
